/* File: logic/eisb_pkg.sv */
// Package with register map, field positions and bus codes for the event flag / status block
//
// Summary of operation
// (RULE1) Receive-done flag, bit 7, sets per good packet, cleared by clear alias.
// (RULE2) Packet-pending bit 6 mirrors nonzero buffer count; writes to it do nothing.
// (RULE3) Receive-activity flag, bit 5, sets when receive data enters the FIFO.
// (RULE4) Transmit-done flag, bit 3, sets once status vector is written back.
// (RULE5) Transmit-abort flag, bit 2, sets when the MAC abandons a frame.
// (RULE6) Descriptor-unavailable flag, bit 1, sets on receive descriptor overrun.
// (RULE7) FIFO-overflow flag, bit 0, sets on receive FIFO overflow.
// (RULE8) Software should change flags through set, clear and invert aliases only.
// (RULE9) Eight-bit buffer count, status bits 23-16, adds descriptors per received packet.
// (RULE10) Software writes the decrement bit once per descriptor after reading a packet.
// (RULE11) Buffer count saturates at 0xff on hardware increment, never wraps.
// (RULE12) Decrement at zero is ignored, count never wraps to maximum.
// (RULE13) Simultaneous increment and decrement leave the count unchanged.
// (RULE14) With flow control on, receive halts at 0xff until a decrement.
// (RULE15) With flow control off, receive continues and count stays saturated.
// (RULE16) Writing the receive start address clears the buffer count.
// (RULE17) Turning the module off keeps the buffer count.
// (RULE18) Module-active bit 7 is high while enabled or finishing a transaction.
// (RULE19) Transmit-active bit 6 follows transmission, cleared while module disabled.
// (RULE20) Receive-active bit 5 follows reception, cleared while module disabled.
// (RULE21) Status bits 31-24, 15-8 and 4-0 read as zero.
// (RULE22) Dropped-frame count increments per accepted frame lost to overrun, sets overflow flag.
// (RULE23) Dropped-frame count clears after a read with byte 0 or 1 enabled.
// (RULE24) Each flag has an enable bit; only enabled flags raise an interrupt.
// (RULE25) One interrupt output is high while any enabled flag is set.
package eisb_pkg;
  localparam int ADDR_W = 8;
  // Register slots, one 16-byte group each: base, clear, set, invert
  localparam logic [3:0] SLOT_CTRL = 4'h0;
  localparam logic [3:0] SLOT_IEN = 4'h1;
  localparam logic [3:0] SLOT_FLAG = 4'h2;
  localparam logic [3:0] SLOT_STAT = 4'h3;
  localparam logic [3:0] SLOT_DROP = 4'h4;
  localparam logic [3:0] SLOT_RXST = 4'h5;
  localparam logic [1:0] AL_BASE = 2'h0;
  localparam logic [1:0] AL_CLR = 2'h1;
  localparam logic [1:0] AL_SET = 2'h2;
  localparam logic [1:0] AL_INV = 2'h3;
  // Control register fields
  localparam int CTRL_DEC_BIT = 0;
  localparam int CTRL_AFC_BIT = 4;
  localparam int CTRL_ON_BIT = 15;
  localparam logic [31:0] CTRL_RW_MASK = 32'h0000_8010;
  // Flag / enable fields
  localparam int FLAG_PEND_BIT = 6;
  localparam logic [7:0] FLAG_STICKY_MASK = 8'haf;
  localparam logic [31:0] IEN_RW_MASK = 32'h0000_00ef;
  // Status fields
  localparam int STAT_CNT_LSB = 16;
  localparam int STAT_MOD_BIT = 7;
  localparam int STAT_TX_BIT = 6;
  localparam int STAT_RX_BIT = 5;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] IEN_RESET = 32'h0000_0000;
  localparam logic [31:0] RXST_RESET = 32'h0000_0000;
  localparam logic [15:0] DROP_RESET = 16'h0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    EISB_RD_IDLE = 2'b01,
    EISB_RD_RESP = 2'b10
  } eisb_rd_state_t;
endpackage

/* File: logic/eisb_cnt_if.sv */
// Interface carrying requests to the packet buffer counter and its value back
`timescale 1ns/100ps
`default_nettype none
interface eisb_cnt_if;
  logic inc;
  logic [7:0] amount;
  logic dec;
  logic clr;
  logic [7:0] count;
  modport ctl_mp (output inc, output amount, output dec, output clr, input count);
  modport cnt_mp (input inc, input amount, input dec, input clr, output count);
endinterface
`default_nettype wire

/* File: logic/eisb_sticky.sv */
// Sticky flag bank: hardware set wins over software write
`timescale 1ns/100ps
`default_nettype none
module eisb_sticky #(
  parameter int W = 8,
  parameter logic [W-1:0] MASK = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] hw_set,
  input wire logic sw_we,
  input wire logic [W-1:0] sw_val,
  output logic [W-1:0] q
);
  logic [W-1:0] q_next;

  // Software value first, then hardware events on top
  always_comb begin
    q_next = (sw_we ? sw_val : q) | hw_set; // [RULE1] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7]
  end

  // Flag storage, only implemented bits kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= q_next & MASK;
    end
  end
endmodule
`default_nettype wire

/* File: logic/eisb_packet_buffer_count.sv */
// Saturating packet buffer counter, raised by hardware and lowered by software
`timescale 1ns/100ps
`default_nettype none
module eisb_packet_buffer_count (
  input wire logic clk,
  input wire logic rst_n,
  eisb_cnt_if.cnt_mp bus
);
  logic [8:0] sum;

  // Wide sum so a carry shows saturation
  always_comb begin
    sum = {1'b0, bus.count} + {1'b0, bus.amount};
  end

  // Count update; no state is tied to module enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.count <= 8'h00;
    end else if (bus.clr) begin
      bus.count <= 8'h00; // [RULE16]
    end else if (bus.inc && bus.dec) begin
      bus.count <= bus.count; // [RULE13]
    end else if (bus.inc) begin
      bus.count <= sum[8] ? eisb_pkg::CNT_MAX : sum[7:0]; // [RULE9] [RULE11] [RULE15]
    end else if (bus.dec && bus.count != 8'h00) begin
      bus.count <= bus.count - 8'h01; // [RULE12]
    end
  end
endmodule
`default_nettype wire

/* File: logic/eisb_top.sv */
// Event flags, status, buffer counter and dropped-frame counter with an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
module eisb_top (
  input wire logic CLK,
  input wire logic RST_N,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Events and levels from the MAC and DMA engines
  input wire logic RX_DONE_EVT,
  input wire logic [7:0] RX_DESC_USED,
  input wire logic RX_DATA_EVT,
  input wire logic TX_DONE_EVT,
  input wire logic TX_ABORT_EVT,
  input wire logic RX_DESC_OVR_EVT,
  input wire logic RX_FIFO_OVF_EVT,
  input wire logic RX_FRAME_DROP_EVT,
  input wire logic TX_IN_PROGRESS,
  input wire logic RX_IN_PROGRESS,
  input wire logic XACT_IN_PROGRESS,
  // Controls back to the engines
  output logic MODULE_ON,
  output logic RX_HALT,
  output logic IRQ
);
  // Bus channel state
  logic aw_ready_reg;
  logic w_ready_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic b_valid_reg;
  logic [1:0] b_resp_reg;
  logic ar_ready_reg;
  logic r_valid_reg;
  logic [31:0] r_data_reg;
  logic [1:0] r_resp_reg;
  eisb_pkg::eisb_rd_state_t rd_state_reg;
  // Register contents
  logic [31:0] ctrl_reg;
  logic [31:0] ien_reg;
  logic [31:0] rxst_reg;
  logic [15:0] drop_reg;
  logic [7:0] flag_q;
  logic mod_act_reg;
  logic tx_act_reg;
  logic rx_act_reg;
  logic halt_reg;
  logic irq_reg;
  // Combinational helpers
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic aw_have_next;
  logic w_have_next;
  logic b_valid_next;
  logic r_valid_next;
  logic [3:0] wr_slot;
  logic [1:0] wr_alias;
  logic [31:0] wr_mask;
  logic wr_mapped;
  logic [31:0] ctrl_new;
  logic [31:0] ien_new;
  logic [31:0] flag_new;
  logic [31:0] drop_new;
  logic dec_req;
  logic [7:0] flag_hw;
  logic [7:0] flag_view;
  logic [31:0] stat_view;
  logic [31:0] rd_mux;
  logic rd_mapped;
  logic drop_read;
  eisb_cnt_if cnt_bus ();

  // Write merge through base, clear, set and invert aliases
  function automatic logic [31:0] alias_apply(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] be,
    input logic [1:0] al
  );
    logic [31:0] res;
    res = old;
    unique case (al)
      eisb_pkg::AL_BASE: res = (old & ~be) | (wd & be);
      eisb_pkg::AL_CLR: res = old & ~(wd & be);
      eisb_pkg::AL_SET: res = old | (wd & be);
      eisb_pkg::AL_INV: res = old ^ (wd & be);
    endcase
    return res;
  endfunction

  // Channel handshakes and next-state of the write path
  always_comb begin
    aw_hs = S_AXI_AWVALID && aw_ready_reg;
    w_hs = S_AXI_WVALID && w_ready_reg;
    ar_hs = S_AXI_ARVALID && ar_ready_reg;
    wr_fire = aw_have_reg && w_have_reg && !b_valid_reg;
    aw_have_next = (aw_have_reg && !wr_fire) || aw_hs;
    w_have_next = (w_have_reg && !wr_fire) || w_hs;
    b_valid_next = wr_fire || (b_valid_reg && !S_AXI_BREADY);
    r_valid_next = ar_hs || (r_valid_reg && !S_AXI_RREADY);
  end

  // Write address and data are taken in either order
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_ready_reg <= 1'b0;
      w_ready_reg <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_ready_reg <= !aw_have_next && !b_valid_next;
      w_ready_reg <= !w_have_next && !b_valid_next;
    end
  end

  // Payload capture on each channel handshake
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (w_hs) begin
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
    end
  end

  // Write decode and merged values for the control, enable, flag and dropped-frame registers
  always_comb begin
    wr_slot = aw_addr_reg[7:4];
    wr_alias = aw_addr_reg[3:2];
    wr_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wr_mapped = (aw_addr_reg[1:0] == 2'h0) && (wr_slot <= eisb_pkg::SLOT_RXST);
    ctrl_new = alias_apply(ctrl_reg, w_data_reg, wr_mask, wr_alias) & eisb_pkg::CTRL_RW_MASK;
    ien_new = alias_apply(ien_reg, w_data_reg, wr_mask, wr_alias) & eisb_pkg::IEN_RW_MASK; // [RULE24]
    flag_new = alias_apply({24'h00_0000, flag_q}, w_data_reg, wr_mask, wr_alias);
    drop_new = alias_apply({16'h0000, drop_reg}, w_data_reg, wr_mask, wr_alias);
    // A one landing on the decrement bit through base, set or invert counts once
    dec_req = wr_fire && wr_mapped && (wr_slot == eisb_pkg::SLOT_CTRL) && (wr_alias != eisb_pkg::AL_CLR)
      && w_strb_reg[0] && w_data_reg[eisb_pkg::CTRL_DEC_BIT]; // [RULE10]
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      b_valid_reg <= 1'b0;
      b_resp_reg <= eisb_pkg::RESP_OKAY;
    end else begin
      b_valid_reg <= b_valid_next;
      if (wr_fire) begin
        b_resp_reg <= wr_mapped ? eisb_pkg::RESP_OKAY : eisb_pkg::RESP_SLVERR;
      end
    end
  end

  // Control, enable and start address registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_reg <= eisb_pkg::CTRL_RESET;
      ien_reg <= eisb_pkg::IEN_RESET;
      rxst_reg <= eisb_pkg::RXST_RESET;
    end else if (wr_fire && wr_mapped) begin
      if (wr_slot == eisb_pkg::SLOT_CTRL) begin
        ctrl_reg <= ctrl_new;
      end
      if (wr_slot == eisb_pkg::SLOT_IEN) begin
        ien_reg <= ien_new;
      end
      if (wr_slot == eisb_pkg::SLOT_RXST) begin
        rxst_reg <= alias_apply(rxst_reg, w_data_reg, wr_mask, wr_alias);
      end
    end
  end

  // Hardware events that raise sticky flags
  always_comb begin
    flag_hw = 8'h00;
    flag_hw[7] = RX_DONE_EVT; // [RULE1]
    flag_hw[5] = RX_DATA_EVT; // [RULE3]
    flag_hw[3] = TX_DONE_EVT; // [RULE4]
    flag_hw[2] = TX_ABORT_EVT; // [RULE5]
    flag_hw[1] = RX_DESC_OVR_EVT; // [RULE6]
    flag_hw[0] = RX_FIFO_OVF_EVT || RX_FRAME_DROP_EVT; // [RULE7] [RULE22]
  end

  eisb_sticky #(
    .W(8),
    .MASK(eisb_pkg::FLAG_STICKY_MASK)
  ) u_flags (
    .clk(CLK),
    .rst_n(RST_N),
    .hw_set(flag_hw),
    .sw_we(wr_fire && wr_mapped && (wr_slot == eisb_pkg::SLOT_FLAG)),
    .sw_val(flag_new[7:0]),
    .q(flag_q)
  );

  // Counter requests: descriptors added per good packet, start address write clears
  assign cnt_bus.inc = RX_DONE_EVT; // [RULE9]
  assign cnt_bus.amount = RX_DESC_USED;
  assign cnt_bus.dec = dec_req; // [RULE10]
  assign cnt_bus.clr = wr_fire && wr_mapped && (wr_slot == eisb_pkg::SLOT_RXST); // [RULE16]

  eisb_packet_buffer_count u_packet_buffer_count (
    .clk(CLK),
    .rst_n(RST_N),
    .bus(cnt_bus)
  );

  // Flag view with pending bit taken live from the count, writes to it ignored
  always_comb begin
    flag_view = flag_q;
    flag_view[eisb_pkg::FLAG_PEND_BIT] = (cnt_bus.count != 8'h00); // [RULE2]
  end

  // Busy bits; counter keeps its value whatever the enable does
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mod_act_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      rx_act_reg <= 1'b0;
    end else begin
      mod_act_reg <= ctrl_reg[eisb_pkg::CTRL_ON_BIT] || (mod_act_reg && XACT_IN_PROGRESS); // [RULE18] [RULE17]
      tx_act_reg <= ctrl_reg[eisb_pkg::CTRL_ON_BIT] && TX_IN_PROGRESS; // [RULE19]
      rx_act_reg <= ctrl_reg[eisb_pkg::CTRL_ON_BIT] && RX_IN_PROGRESS; // [RULE20]
    end
  end

  // Status view, unimplemented bits held at zero
  always_comb begin
    stat_view = 32'h0000_0000; // [RULE21]
    stat_view[eisb_pkg::STAT_CNT_LSB +: 8] = cnt_bus.count; // [RULE9]
    stat_view[eisb_pkg::STAT_MOD_BIT] = mod_act_reg;
    stat_view[eisb_pkg::STAT_TX_BIT] = tx_act_reg;
    stat_view[eisb_pkg::STAT_RX_BIT] = rx_act_reg;
  end

  // Automatic flow control halts receive while the count sits at its ceiling
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      halt_reg <= 1'b0;
    end else begin
      halt_reg <= ctrl_reg[eisb_pkg::CTRL_AFC_BIT] && (cnt_bus.count == eisb_pkg::CNT_MAX); // [RULE14] [RULE15]
    end
  end

  // Single interrupt from enabled flags
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flag_view & ien_reg[7:0]); // [RULE24] [RULE25]
    end
  end

  // Read mux; every alias of a slot reads the base value
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_mapped = (S_AXI_ARADDR[1:0] == 2'h0);
    unique case (S_AXI_ARADDR[7:4])
      eisb_pkg::SLOT_CTRL: rd_mux = ctrl_reg;
      eisb_pkg::SLOT_IEN: rd_mux = ien_reg;
      eisb_pkg::SLOT_FLAG: rd_mux = {24'h00_0000, flag_view};
      eisb_pkg::SLOT_STAT: rd_mux = stat_view;
      eisb_pkg::SLOT_DROP: rd_mux = {16'h0000, drop_reg};
      eisb_pkg::SLOT_RXST: rd_mux = rxst_reg;
      default: rd_mapped = 1'b0;
    endcase
    if (!rd_mapped) begin
      rd_mux = 32'h0000_0000;
    end
    // A bus read always enables the low bytes, so it clears unless a dropped-frame write lands in the same cycle
    drop_read = ar_hs && rd_mapped && (S_AXI_ARADDR[7:4] == eisb_pkg::SLOT_DROP); // [RULE23]
  end

  // Read channel sequencing
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rd_state_reg <= eisb_pkg::EISB_RD_IDLE;
      ar_ready_reg <= 1'b0;
      r_valid_reg <= 1'b0;
    end else begin
      r_valid_reg <= r_valid_next;
      ar_ready_reg <= !r_valid_next;
      unique case (rd_state_reg)
        eisb_pkg::EISB_RD_IDLE: begin
          if (ar_hs) begin
            rd_state_reg <= eisb_pkg::EISB_RD_RESP;
          end
        end
        eisb_pkg::EISB_RD_RESP: begin
          if (S_AXI_RREADY) begin
            rd_state_reg <= eisb_pkg::EISB_RD_IDLE;
          end
        end
      endcase
    end
  end

  // Read data captured at the address handshake
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r_data_reg <= 32'h0000_0000;
      r_resp_reg <= eisb_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      r_data_reg <= rd_mux;
      r_resp_reg <= rd_mapped ? eisb_pkg::RESP_OKAY : eisb_pkg::RESP_SLVERR;
    end
  end

  // Dropped-frame counter: write, then read clear, then increment on top
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      drop_reg <= eisb_pkg::DROP_RESET;
    end else if (wr_fire && wr_mapped && (wr_slot == eisb_pkg::SLOT_DROP)) begin
      drop_reg <= drop_new[15:0] + {15'h0000, RX_FRAME_DROP_EVT};
    end else if (drop_read) begin
      drop_reg <= {15'h0000, RX_FRAME_DROP_EVT}; // [RULE23]
    end else if (RX_FRAME_DROP_EVT) begin
      drop_reg <= drop_reg + 16'h0001; // [RULE22]
    end
  end

  // Outputs straight from flip-flops
  assign S_AXI_AWREADY = aw_ready_reg;
  assign S_AXI_WREADY = w_ready_reg;
  assign S_AXI_BVALID = b_valid_reg;
  assign S_AXI_BRESP = b_resp_reg;
  assign S_AXI_ARREADY = ar_ready_reg;
  assign S_AXI_RVALID = r_valid_reg;
  assign S_AXI_RDATA = r_data_reg;
  assign S_AXI_RRESP = r_resp_reg;
  assign MODULE_ON = ctrl_reg[eisb_pkg::CTRL_ON_BIT];
  assign RX_HALT = halt_reg;
  assign IRQ = irq_reg;
endmodule
`default_nettype wire

/* File: dv/eisb_checker.sv */
// Port-level checker for the event flag, status and buffer counter block
`timescale 1ns/100ps
`default_nettype none
module eisb_checker (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic RX_DONE_EVT,
  input wire logic TX_IN_PROGRESS,
  input wire logic RX_IN_PROGRESS,
  input wire logic XACT_IN_PROGRESS,
  input wire logic MODULE_ON,
  input wire logic RX_HALT,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic ar_st;
  logic st_q;
  // Read of the status slot taken at this edge
  assign ar_st = S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[7:4] == eisb_pkg::SLOT_STAT
    && S_AXI_ARADDR[1:0] == 2'h0;
  // Remembers whether the pending read answer belongs to the status slot
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= 1'b0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      st_q <= ar_st;
    end
  end
  AST_STAT_RESV: assert property (S_AXI_RVALID && st_q |-> (S_AXI_RDATA & 32'hff00_ff1f) == 32'h0)
    else $error("status reserved bits not zero");
  AST_MOD_BUSY: assert property (ar_st && $past(MODULE_ON) |=> S_AXI_RDATA[7])
    else $error("module active low while enabled");
  AST_MOD_IDLE: assert property (ar_st && !$past(MODULE_ON) && !$past(XACT_IN_PROGRESS) |=> !S_AXI_RDATA[7])
    else $error("module active high while idle and off");
  AST_TX_BUSY: assert property (ar_st && $past(MODULE_ON) && $past(TX_IN_PROGRESS) |=> S_AXI_RDATA[6])
    else $error("transmit active missing");
  AST_RX_BUSY: assert property (ar_st && $past(MODULE_ON) && $past(RX_IN_PROGRESS) |=> S_AXI_RDATA[5])
    else $error("receive active missing");
  AST_OFF_IDLE: assert property (ar_st && !$past(MODULE_ON) |=> S_AXI_RDATA[6:5] == 2'b00)
    else $error("busy bits set while module off");
  AST_HALT_RISE: assert property ($rose(RX_HALT) |-> $past(RX_DONE_EVT, 2) || $past(S_AXI_BVALID))
    else $error("receive halt rose without cause");
  AST_HALT_FALL: assert property ($fell(RX_HALT) |-> $past(S_AXI_BVALID))
    else $error("receive halt fell without a write");
  AST_IRQ_FALL: assert property ($fell(IRQ) |-> $past(S_AXI_BVALID))
    else $error("interrupt fell without a write");
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  // Main scenarios reached
  COV_STAT: cover property (ar_st);
  COV_HALT: cover property ($rose(RX_HALT));
  COV_IRQ: cover property ($fell(IRQ));
endmodule
`default_nettype wire

/* File: dv/test_eth_irq_status_bufcount.sv */
// Self-checking bench for the event flag, status and buffer counter block
`timescale 1ns/100ps
`default_nettype none
module test_eth_irq_status_bufcount;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, module_on, rx_halt, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [6:0] ev = 7'h0;
  logic [7:0] desc = 8'h0;
  logic tx_ip = 1'b0, rx_ip = 1'b0, xa_ip = 1'b0;
  int error_cnt = 0;
  int n_tests = 0;
  logic [7:0] ra [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50};
  int fb [7] = '{7, 5, 3, 2, 1, 0, 0};

  eisb_top eisb_top_i (
    .CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .RX_DONE_EVT(ev[0]), .RX_DESC_USED(desc), .RX_DATA_EVT(ev[1]), .TX_DONE_EVT(ev[2]),
    .TX_ABORT_EVT(ev[3]), .RX_DESC_OVR_EVT(ev[4]), .RX_FIFO_OVF_EVT(ev[5]), .RX_FRAME_DROP_EVT(ev[6]),
    .TX_IN_PROGRESS(tx_ip), .RX_IN_PROGRESS(rx_ip), .XACT_IN_PROGRESS(xa_ip),
    .MODULE_ON(module_on), .RX_HALT(rx_halt), .IRQ(irq)
  );

  // 10 MHz clock
  always #50 clk = ~clk;

  // Compares response and data in one go
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = eisb_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    rsp = bresp;
    bready <= 1'b0;
    if (n >= 50) error_cnt++;
    chk({rsp, 32'h0}, {r, 32'h0});
  endtask

  // Bus read compared with an expected word
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = eisb_pkg::RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n >= 50) error_cnt++;
    chk({rsp, rd}, {r, e});
  endtask

  // One-cycle engine event with a descriptor count
  task automatic pulse(input logic [6:0] m, input logic [7:0] n);
    @(posedge clk);
    ev <= m;
    desc <= n;
    @(posedge clk);
    ev <= 7'h0;
    repeat (3) @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (ra[i]) rc(ra[i], 32'h0);
    wr(8'h18, 32'hff);
    rc(8'h10, 32'hef);
    for (int i = 0; i < 7; i++) begin
      pulse(7'h1 << i, 8'h0);
      rc(8'h20, 32'h1 << fb[i]);
      chk({33'h0, irq}, 34'h1);
      wr(8'h24, 32'h1 << fb[i]);
      rc(8'h20, 32'h0);
      chk({33'h0, irq}, 34'h0);
    end
    rc(8'h40, 32'h1);
    rc(8'h40, 32'h0);
    // Masked flag raises no interrupt
    wr(8'h14, 32'hef);
    pulse(7'h1, 8'h0);
    chk({33'h0, irq}, 34'h0);
    wr(8'h24, 32'h80);
    wr(8'h28, 32'h40);
    rc(8'h20, 32'h0);
    // Count up by descriptors, down by software, not below zero
    pulse(7'h1, 8'h03);
    rc(8'h30, 32'h0003_0000);
    rc(8'h20, 32'hc0);
    wr(8'h24, 32'h80);
    repeat (4) wr(8'h08, 32'h1);
    rc(8'h30, 32'h0);
    rc(8'h20, 32'h0);
    // Saturation and flow control
    pulse(7'h1, 8'hfe);
    pulse(7'h1, 8'h05);
    rc(8'h30, 32'h00ff_0000);
    wr(8'h08, 32'h10);
    repeat (2) @(posedge clk);
    chk({33'h0, rx_halt}, 34'h1);
    wr(8'h08, 32'h1);
    repeat (2) @(posedge clk);
    chk({33'h0, rx_halt}, 34'h0);
    rc(8'h30, 32'h00fe_0000);
    // Decrement lands in the cycle of a one-descriptor packet, count stays
    fork
      wr(8'h08, 32'h1);
      begin
        repeat (2) @(posedge clk);
        ev <= 7'h1;
        desc <= 8'h01;
        @(posedge clk);
        ev <= 7'h0;
      end
    join
    rc(8'h30, 32'h00fe_0000);
    pulse(7'h1, 8'h01);
    chk({33'h0, rx_halt}, 34'h1);
    wr(8'h04, 32'h10);
    pulse(7'h1, 8'h01);
    chk({33'h0, rx_halt}, 34'h0);
    rc(8'h30, 32'h00ff_0000);
    // Module enable, busy levels and count kept while off
    wr(8'h08, 32'h8000);
    chk({33'h0, module_on}, 34'h1);
    tx_ip <= 1'b1;
    rx_ip <= 1'b1;
    xa_ip <= 1'b1;
    repeat (2) @(posedge clk);
    rc(8'h30, 32'h00ff_00e0);
    wr(8'h04, 32'h8000);
    repeat (2) @(posedge clk);
    rc(8'h30, 32'h00ff_0080);
    xa_ip <= 1'b0;
    tx_ip <= 1'b0;
    rx_ip <= 1'b0;
    repeat (2) @(posedge clk);
    rc(8'h30, 32'h00ff_0000);
    // Start address write clears the count
    wr(8'h50, 32'h1234_5678);
    rc(8'h50, 32'h1234_5678);
    rc(8'h30, 32'h0);
    // Two drops, then read-clear
    pulse(7'h40, 8'h0);
    pulse(7'h40, 8'h0);
    rc(8'h40, 32'h2);
    rc(8'h40, 32'h0);
    // Read-only status and unmapped places
    wr(8'h30, 32'hffff_ffff);
    rc(8'h30, 32'h0);
    rc(8'h60, 32'h0, eisb_pkg::RESP_SLVERR);
    wr(8'h62, 32'h1, eisb_pkg::RESP_SLVERR);
    report_and_stop();
  end
endmodule

bind eisb_top eisb_checker eisb_checker_i (
  .CLK(CLK), .RST_N(RST_N), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .RX_DONE_EVT(RX_DONE_EVT), .TX_IN_PROGRESS(TX_IN_PROGRESS), .RX_IN_PROGRESS(RX_IN_PROGRESS),
  .XACT_IN_PROGRESS(XACT_IN_PROGRESS), .MODULE_ON(MODULE_ON), .RX_HALT(RX_HALT), .IRQ(IRQ)
);
`default_nettype wire
